// ### dv/ascst_peer.sv
// Far-side serial party: receive events, transmit takeover, send gate pin
`timescale 1ns/100ps
`default_nettype none
module ascst_peer (
   input  wire logic  i_clk,
   output logic [7:0] o_rx_byte,
   output logic       o_rx_load,
   output logic       o_par_bad,
   output logic       o_stop_bad,
   output logic       o_shift_full,
   output logic       o_tx_move,
   output logic       o_pin
);
   // Idle levels at time zero
   initial begin
      o_rx_byte = 8'h00;
      o_rx_load = 1'b0;
      o_par_bad = 1'b0;
      o_stop_bad = 1'b0;
      o_shift_full = 1'b0;
      o_tx_move = 1'b0;
      o_pin = 1'b0;
   end
   // One received byte; qualifiers flip afterwards so stale values are never trusted
   task send(input logic [7:0] b, input logic pbad, input logic sbad);
      @(posedge i_clk);
      o_rx_byte <= b;
      o_rx_load <= 1'b1;
      o_par_bad <= pbad;
      o_stop_bad <= sbad;
      @(posedge i_clk);
      o_rx_load <= 1'b0;
      o_rx_byte <= ~b;
      o_par_bad <= ~pbad;
      o_stop_bad <= ~sbad;
   endtask : send
   // Shifter fills again before software read
   task overrun;
      @(posedge i_clk);
      o_shift_full <= 1'b1;
      @(posedge i_clk);
      o_shift_full <= 1'b0;
   endtask : overrun
   // Transmit shifter takes the pending byte
   task take_tx;
      @(posedge i_clk);
      o_tx_move <= 1'b1;
      @(posedge i_clk);
      o_tx_move <= 1'b0;
   endtask : take_tx
   // Remote holds off our transmitter while high
   task gate(input logic v);
      @(posedge i_clk);
      o_pin <= v;
   endtask : gate
endmodule : ascst_peer
`default_nettype wire

// ### dv/ascst_props.sv
// Port-level checks for the serial channel status block
`timescale 1ns/100ps
`default_nettype none
module ascst_props (
   input wire logic        I_MCLK,
   input wire logic        I_RESETN,
   input wire logic        I_WB_CYC,
   input wire logic        I_WB_STB,
   input wire logic        I_WB_WE,
   input wire logic [3:0]  I_WB_SEL,
   input wire logic [ascst_pkg::ASCST_ADDR_W-1:0] I_WB_ADR,
   input wire logic [31:0] I_WB_DAT,
   input wire logic [31:0] O_WB_DAT,
   input wire logic        O_WB_ACK,
   input wire logic        I_SHARED_PIN,
   input wire logic        I_CARRIER_HIGH,
   input wire logic        I_IO_HALT,
   input wire logic        I_RX_LOAD,
   input wire logic [7:0]  O_TX_BYTE,
   input wire logic        O_SEND_GATE,
   input wire logic        O_CSIO_RX
);
   import ascst_pkg::*;
   // ------------------------------
   // Taken requests
   // ------------------------------
   logic req;
   logic st_rd;
   logic tx_wr;
   // A request counts once, at the edge before its ack
   assign req   = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
   assign st_rd = req & ~I_WB_WE & (I_WB_ADR[5:2] == ASCST_IDX_STATUS);
   assign tx_wr = req & I_WB_WE & I_WB_SEL[0] & (I_WB_ADR[5:2] == ASCST_IDX_TXDATA);
   default clocking cb @(posedge I_MCLK);
   endclocking
   default disable iff (!I_RESETN);
   // ------------------------------
   // Properties
   // ------------------------------
   ack_pulse_a: assert property (O_WB_ACK |=> !O_WB_ACK)
      else $error("ack longer than one cycle");
   ack_latency_a: assert property (req |=> O_WB_ACK)
      else $error("ack late");
   read_idle_a: assert property (!O_WB_ACK |-> O_WB_DAT == 32'h0)
      else $error("read data outside ack");
   tx_byte_a: assert property (tx_wr |=> O_TX_BYTE == $past(I_WB_DAT[7:0]))
      else $error("transmit byte not loaded");
   send_gate_a: assert property (O_SEND_GATE |-> $past(I_SHARED_PIN) && O_CSIO_RX)
      else $error("send gate without pin");
   csio_rx_a: assert property (!O_CSIO_RX |-> !$past(I_SHARED_PIN) && !O_SEND_GATE)
      else $error("clocked rx low without pin");
   rx_full_a: assert property ((I_RX_LOAD && !I_CARRIER_HIGH && !I_IO_HALT) ##1
      (st_rd && !I_CARRIER_HIGH && !I_IO_HALT) |=> O_WB_DAT[7]) else $error("full not set");
   halt_clear_a: assert property (st_rd && I_IO_HALT && $past(I_IO_HALT)
      |=> O_WB_DAT[7:4] == 4'h0 && O_WB_DAT[1]) else $error("halt state wrong");
   gate_empty_a: assert property (st_rd && O_SEND_GATE && !$past(I_IO_HALT)
      |=> !O_WB_DAT[1]) else $error("empty while gate high");
   cover property (st_rd ##1 O_WB_DAT[7]);
   cover property (tx_wr);
   cover property (st_rd && O_SEND_GATE);
endmodule : ascst_props
bind ascst_top ascst_props u_props (.I_MCLK(I_MCLK), .I_RESETN(I_RESETN),
   .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_SEL(I_WB_SEL),
   .I_WB_ADR(I_WB_ADR), .I_WB_DAT(I_WB_DAT), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK),
   .I_SHARED_PIN(I_SHARED_PIN), .I_CARRIER_HIGH(I_CARRIER_HIGH), .I_IO_HALT(I_IO_HALT),
   .I_RX_LOAD(I_RX_LOAD), .O_TX_BYTE(O_TX_BYTE), .O_SEND_GATE(O_SEND_GATE),
   .O_CSIO_RX(O_CSIO_RX));
`default_nettype wire

// ### dv/ascst_top_test.sv
// Self-checking bench for the serial channel status block
`timescale 1ns/100ps
`default_nettype none
module ascst_top_test;
   import ascst_pkg::*;
   localparam logic [5:0] A_CT = {ASCST_IDX_CONTROL, 2'b00};
   localparam logic [5:0] A_RX = {ASCST_IDX_RXDATA, 2'b00};
   localparam logic [5:0] A_TX = {ASCST_IDX_TXDATA, 2'b00};
   localparam logic [5:0] A_EV = {ASCST_IDX_IRQST, 2'b00};
   localparam logic [5:0] A_MK = {ASCST_IDX_IRQMSK, 2'b00};
   localparam logic [5:0] A_ST = {ASCST_IDX_STATUS, 2'b00};
   logic        clk, rst_n, cyc, stb, we, carrier, halt, ack, irq, gate, csio;
   logic        load, pbad, sbad, sfull, move, pin;
   logic [3:0]  sel;
   logic [5:0]  adr;
   logic [31:0] wdat, rdat;
   logic [7:0]  txb, rxb, got;
   int          failures, compares;
   ascst_top dut (.I_MCLK(clk), .I_RESETN(rst_n), .I_WB_CYC(cyc), .I_WB_STB(stb),
      .I_WB_WE(we), .I_WB_SEL(sel), .I_WB_ADR(adr), .I_WB_DAT(wdat), .O_WB_DAT(rdat),
      .O_WB_ACK(ack), .I_SHARED_PIN(pin), .I_CARRIER_HIGH(carrier), .I_IO_HALT(halt),
      .I_RX_BYTE(rxb), .I_RX_LOAD(load), .I_RX_PAR_BAD(pbad), .I_RX_STOP_BAD(sbad),
      .I_RX_SHIFT_FULL(sfull), .I_TX_MOVE(move), .O_TX_BYTE(txb), .O_SEND_GATE(gate),
      .O_CSIO_RX(csio), .O_IRQ(irq));
   ascst_peer peer (.i_clk(clk), .o_rx_byte(rxb), .o_rx_load(load), .o_par_bad(pbad),
      .o_stop_bad(sbad), .o_shift_full(sfull), .o_tx_move(move), .o_pin(pin));
   // Free-running clock, 50 ns period
   always #25 clk = ~clk;
   // ------------------------------
   // Checks and bus cycles
   // ------------------------------
   task close_out;
      if (failures == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : close_out
   task cmp8(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         failures++;
         $display("unexpected at %0t: byte %h not %h", $time, g, e);
      end
   endtask : cmp8
   task cmp1(input logic g, input logic e);
      compares++;
      if (g !== e) begin
         failures++;
         $display("unexpected at %0t: pin %b not %b", $time, g, e);
      end
   endtask : cmp1
   // Entered just after an edge; holds the request until ack, then one idle cycle
   task wb(input logic w, input logic [5:0] a, input logic [7:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= {24'h0, d};
      sel <= 4'h1;
      do @(posedge clk); while (ack !== 1'b1);
      got = rdat[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : wb
   task wr(input logic [5:0] a, input logic [7:0] d);
      wb(1'b1, a, d);
   endtask : wr
   task rd(input logic [5:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00);
      cmp8(got, e);
   endtask : rd
   // Watchdog: whole sequence needs well under 1000 cycles
   initial begin
      repeat (4000) @(posedge clk);
      failures++;
      close_out;
   end
   // ------------------------------
   // Test sequence
   // ------------------------------
   initial begin
      {clk, rst_n, cyc, stb, we, carrier, halt} = 7'h00;
      {sel, adr, wdat, failures, compares} = '0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      rd(A_CT, ASCST_RST_CTRL);
      wr(6'h3C, 8'hFF);
      rd(6'h3C, 8'h00);
      rd(A_ST, 8'h02);
      peer.send(8'hA5, 1'b1, 1'b1);
      rd(A_ST, 8'h92);
      rd(A_RX, 8'hA5);
      rd(A_ST, 8'h12);
      wr(A_CT, 8'h0A);
      rd(A_ST, 8'h12);
      peer.send(8'h3C, 1'b1, 1'b0);
      peer.overrun;
      rd(A_ST, 8'hF2);
      wr(A_CT, 8'h02);
      rd(A_ST, 8'h82);
      peer.overrun;
      carrier <= 1'b1;
      @(posedge clk);
      rd(A_ST, 8'h02);
      carrier <= 1'b0;
      wr(A_TX, 8'h5A);
      cmp8(txb, 8'h5A);
      rd(A_ST, 8'h00);
      peer.take_tx;
      rd(A_ST, 8'h02);
      peer.send(8'h11, 1'b0, 1'b0);
      wr(A_TX, 8'hC3);
      halt <= 1'b1;
      @(posedge clk);
      rd(A_ST, 8'h02);
      halt <= 1'b0;
      wr(A_ST, 8'hF4);
      peer.gate(1'b1);
      repeat (2) @(posedge clk);
      cmp1(gate, 1'b1);
      cmp1(csio, 1'b1);
      rd(A_ST, 8'h04);
      wr(A_ST, 8'h00);
      cmp1(gate, 1'b0);
      peer.gate(1'b0);
      repeat (2) @(posedge clk);
      cmp1(csio, 1'b0);
      halt <= 1'b1;
      @(posedge clk);
      halt <= 1'b0;
      wr(A_ST, 8'h01);
      cmp1(irq, 1'b1);
      wr(A_ST, 8'h08);
      cmp1(irq, 1'b0);
      peer.send(8'h77, 1'b0, 1'b0);
      repeat (2) @(posedge clk);
      cmp1(irq, 1'b1);
      rd(A_EV, 8'h03);
      rd(A_EV, 8'h00);
      wr(A_MK, 8'h01);
      rd(A_RX, 8'h77);
      peer.send(8'h66, 1'b0, 1'b0);
      wr(A_ST, 8'h00);
      cmp1(irq, 1'b1);
      rd(A_EV, 8'h01);
      cmp1(irq, 1'b0);
      rd(A_RX, 8'h66);
      wr(A_ST, 8'h08);
      carrier <= 1'b1;
      repeat (2) @(posedge clk);
      carrier <= 1'b0;
      rd(A_EV, 8'h04);
      close_out;
   end
endmodule : ascst_top_test
`default_nettype wire

// ### logic/ascst_flags.sv
// Flag bank: receive-full, error and transmit-empty flags
`timescale 1ns/100ps
`default_nettype none
module ascst_flags (
   input  wire logic i_clk,
   input  wire logic i_resetn,
   ascst_ev_if.sink  ev
);
   import ascst_pkg::*;
   logic rdf_r, ovr_r, par_r, frm_r, tde_r;

   // Receive-full: load sets and wins over a read in the same cycle
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rdf_r <= 1'b0;                                   // [R3]
      end else if (ev.cd_high || ev.halt) begin
         rdf_r <= 1'b0;                                   // [R3]
      end else if (ev.rx_load) begin
         rdf_r <= 1'b1;                                   // [R1] [R2]
      end else if (ev.rx_read) begin
         rdf_r <= 1'b0;                                   // [R3]
      end
   end

   // Error flags: a set in the clearing cycle survives the clear
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ovr_r <= 1'b0;
         par_r <= 1'b0;
         frm_r <= 1'b0;                                   // [R5]
      end else if (ev.cd_high || ev.halt) begin
         ovr_r <= 1'b0;
         par_r <= 1'b0;
         frm_r <= 1'b0;                                   // [R5]
      end else begin
         ovr_r <= (rdf_r && ev.rx_shift_full) || (ovr_r && !ev.err_clear); // [R4] [R5]
         par_r <= (ev.rx_load && ev.rx_par_bad && ev.par_en)
                  || (par_r && !ev.err_clear);            // [R6] [R5]
         frm_r <= (ev.rx_load && ev.rx_stop_bad)
                  || (frm_r && !ev.err_clear);            // [R7] [R5]
      end
   end

   // Transmit-empty: held low while the send gate is high, unless halt forces it high
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         tde_r <= 1'b1;                                   // [R12]
      end else if (ev.halt) begin
         tde_r <= 1'b1;                                   // [R12]
      end else if (ev.gate_high) begin
         tde_r <= 1'b0;                                   // [R13]
      end else if (ev.tx_move) begin
         tde_r <= 1'b1;                                   // [R11]
      end else if (ev.tx_write) begin
         tde_r <= 1'b0;                                   // [R11]
      end
   end

   assign ev.flags = {rdf_r, ovr_r, par_r, frm_r, 2'b00, tde_r, 1'b0};
endmodule : ascst_flags
`default_nettype wire

// ### logic/ascst_top.sv
// Status, interrupt and pin-select logic of serial channel 1 with a Wishbone slave
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// [R1] Byte loaded into receive register sets full
// [R2] Errored bytes still load and set full
// [R3] Full clears on read, carrier, halt, reset
// [R4] Overrun when full and shifter fills
// [R5] Errors clear on zero write, carrier, halt
// [R6] Parity error only while parity enabled
// [R7] Framing error on zero stop bit
// [R8] Receive interrupt when enabled and flag set
// [R9] Carrier rising edge requests receive interrupt
// [R10] Select bit routes shared pin function
// [R11] Transmit write clears empty, move sets it
// [R12] Empty forced high in halt and reset
// [R13] Send gate high holds empty low
// [R14] Transmit interrupt while enabled and empty
// [R15] One combined level interrupt request
module ascst_top (
   input  wire logic                      I_MCLK,
   input  wire logic                      I_RESETN,
   input  wire logic                      I_WB_CYC,
   input  wire logic                      I_WB_STB,
   input  wire logic                      I_WB_WE,
   input  wire logic [3:0]                I_WB_SEL,
   input  wire logic [ascst_pkg::ASCST_ADDR_W-1:0] I_WB_ADR,
   input  wire logic [31:0]               I_WB_DAT,
   output logic      [31:0]               O_WB_DAT,
   output logic                           O_WB_ACK,
   input  wire logic                      I_SHARED_PIN,
   input  wire logic                      I_CARRIER_HIGH,
   input  wire logic                      I_IO_HALT,
   input  wire logic [7:0]                I_RX_BYTE,
   input  wire logic                      I_RX_LOAD,
   input  wire logic                      I_RX_PAR_BAD,
   input  wire logic                      I_RX_STOP_BAD,
   input  wire logic                      I_RX_SHIFT_FULL,
   input  wire logic                      I_TX_MOVE,
   output logic      [7:0]                O_TX_BYTE,
   output logic                           O_SEND_GATE,
   output logic                           O_CSIO_RX,
   output logic                           O_IRQ
);
   import ascst_pkg::*;

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [7:0]            ctrl_r;
   logic                  rie_r, sel_r, tie_r;
   logic [7:0]            rxd_r;
   logic [ASCST_EV_W-1:0] evst_r, evmsk_r;
   logic                  cd_d_r;
   logic                  rx_req_d_r, tx_req_d_r;
   logic                  wr_stb, rd_stb;
   logic [3:0]            idx;
   logic [7:0]            wbyte;
   logic [7:0]            stat;
   logic                  rx_req, tx_req, cd_rise;
   logic [31:0]           rdata;
   ascst_ev_if            ev ();

   // Word index from byte address; new access only while ack is low
   function automatic logic [3:0] word_idx(input logic [ASCST_ADDR_W-1:0] a);
      return a[ASCST_ADDR_W-1:2];
   endfunction : word_idx

   assign idx    = word_idx(I_WB_ADR);
   assign wr_stb = I_WB_CYC && I_WB_STB && I_WB_WE && !O_WB_ACK && I_WB_SEL[0];
   assign rd_stb = I_WB_CYC && I_WB_STB && !I_WB_WE && !O_WB_ACK;
   assign wbyte  = I_WB_DAT[7:0];

   // ---------------------------------------------------------------
   // Flag bank hookup
   // ---------------------------------------------------------------
   assign ev.rx_load       = I_RX_LOAD;
   assign ev.rx_par_bad    = I_RX_PAR_BAD;
   assign ev.rx_stop_bad   = I_RX_STOP_BAD;
   assign ev.rx_shift_full = I_RX_SHIFT_FULL;
   assign ev.rx_read       = rd_stb && (idx == ASCST_IDX_RXDATA);
   assign ev.tx_write      = wr_stb && (idx == ASCST_IDX_TXDATA);
   assign ev.tx_move       = I_TX_MOVE;
   // Clear acts on any write of 0 to the clear bit; ctrl_r keeps the written bit only for readback
   assign ev.err_clear     = wr_stb && (idx == ASCST_IDX_CONTROL) && !wbyte[ASCST_B_EFC];
   assign ev.par_en        = ctrl_r[ASCST_B_PEN];
   assign ev.cd_high       = I_CARRIER_HIGH;
   assign ev.halt          = I_IO_HALT;
   // Send gate only counts while the pin is routed to it
   assign ev.gate_high     = sel_r && I_SHARED_PIN;                  // [R13]

   ascst_flags u_flags (
      .i_clk    (I_MCLK),
      .i_resetn (I_RESETN),
      .ev       (ev)
   );

   // Status byte as software reads it
   always_comb begin
      stat              = ev.flags;
      stat[ASCST_B_RIE] = rie_r;
      stat[ASCST_B_SEL] = sel_r;
      stat[ASCST_B_TIE] = tie_r;
   end

   // ---------------------------------------------------------------
   // Interrupt requests
   // ---------------------------------------------------------------
   assign cd_rise = I_CARRIER_HIGH && !cd_d_r;                       // [R9]
   assign rx_req  = rie_r && (|stat[ASCST_B_RDF:ASCST_B_FRM]);      // [R8]
   assign tx_req  = tie_r && stat[ASCST_B_TDE];                      // [R14]

   // Carrier edge detector history
   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         cd_d_r <= 1'b0;
      end else begin
         cd_d_r <= I_CARRIER_HIGH;
      end
   end

   // Request history for rising-edge event capture
   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         rx_req_d_r <= 1'b0;
         tx_req_d_r <= 1'b0;
      end else begin
         rx_req_d_r <= rx_req;
         tx_req_d_r <= tx_req;
      end
   end

   // Sticky events; a new event beats the read that clears them
   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         evst_r <= '0;
      end else begin
         evst_r <= (rd_stb && idx == ASCST_IDX_IRQST) ? '0 : evst_r;
         if (rx_req && !rx_req_d_r) begin
            evst_r[ASCST_E_RX] <= 1'b1;
         end
         if (tx_req && !tx_req_d_r) begin
            evst_r[ASCST_E_TX] <= 1'b1;
         end
         if (cd_rise && rie_r) begin
            evst_r[ASCST_E_CD] <= 1'b1;                              // [R9]
         end
      end
   end

   // Level request: live conditions plus any sticky event enabled in the mask
   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_IRQ <= 1'b0;
      end else begin
         O_IRQ <= rx_req || tx_req || (|(evst_r & evmsk_r));         // [R15] [R8] [R14]
      end
   end

   // ---------------------------------------------------------------
   // Software-written registers
   // ---------------------------------------------------------------
   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         rie_r <= 1'b0;
         sel_r <= 1'b0;
         tie_r <= 1'b0;                                              // [R14]
      end else if (wr_stb && idx == ASCST_IDX_STATUS) begin
         rie_r <= wbyte[ASCST_B_RIE];
         sel_r <= wbyte[ASCST_B_SEL];
         tie_r <= wbyte[ASCST_B_TIE];
      end
   end

   // Control subset: parity select and the rest stored for readback
   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         ctrl_r <= ASCST_RST_CTRL;
      end else if (wr_stb && idx == ASCST_IDX_CONTROL) begin
         ctrl_r <= wbyte;
      end
   end

   // Mask register
   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         evmsk_r <= '0;
      end else if (wr_stb && idx == ASCST_IDX_IRQMSK) begin
         evmsk_r <= wbyte[ASCST_EV_W-1:0];
      end
   end

   // Receive data register loads on every arrival, errored or not
   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         rxd_r <= ASCST_RST_ZERO;
      end else if (I_RX_LOAD) begin
         rxd_r <= I_RX_BYTE;                                         // [R2]
      end
   end

   // Transmit data register
   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_TX_BYTE <= ASCST_RST_ZERO;
      end else if (ev.tx_write) begin
         O_TX_BYTE <= wbyte;
      end
   end

   // ---------------------------------------------------------------
   // Shared pin routing, registered so outputs come from flops
   // ---------------------------------------------------------------
   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_SEND_GATE <= 1'b0;
         O_CSIO_RX   <= 1'b1;
      end else begin
         O_SEND_GATE <= sel_r ? I_SHARED_PIN : 1'b0;                 // [R10]
         O_CSIO_RX   <= sel_r ? 1'b1 : I_SHARED_PIN;                 // [R10]
      end
   end

   // ---------------------------------------------------------------
   // Wishbone read mux and ack; unmapped reads return zero
   // ---------------------------------------------------------------
   always_comb begin
      rdata = '0;
      if (idx == ASCST_IDX_STATUS) begin
         rdata[7:0] = stat;
      end else if (idx == ASCST_IDX_CONTROL) begin
         rdata[7:0] = ctrl_r;
      end else if (idx == ASCST_IDX_RXDATA) begin
         rdata[7:0] = rxd_r;
      end else if (idx == ASCST_IDX_TXDATA) begin
         rdata[7:0] = O_TX_BYTE;
      end else if (idx == ASCST_IDX_IRQST) begin
         rdata[ASCST_EV_W-1:0] = evst_r;
      end else if (idx == ASCST_IDX_IRQMSK) begin
         rdata[ASCST_EV_W-1:0] = evmsk_r;
      end
   end

   // One-cycle ack, data registered with it
   always_ff @(posedge I_MCLK or negedge I_RESETN) begin
      if (!I_RESETN) begin
         O_WB_ACK <= 1'b0;
         O_WB_DAT <= '0;
      end else begin
         O_WB_ACK <= I_WB_CYC && I_WB_STB && !O_WB_ACK;
         O_WB_DAT <= rd_stb ? rdata : '0;
      end
   end
endmodule : ascst_top
`default_nettype wire

// ### shared/ascst_ev_if.sv
// Interface carrying receive and transmit events into the flag bank
`timescale 1ns/100ps
`default_nettype none
interface ascst_ev_if;
   logic       rx_load;     // Byte moved shifter to receive_data_register
   logic       rx_par_bad;
   logic       rx_stop_bad;
   logic       rx_shift_full;
   logic       rx_read;     // Software read of receive_data_register
   logic       tx_write;    // Software write of transmit_data_register
   logic       tx_move;     // Byte moved to transmit_shift_register
   logic       err_clear;   // error_flag_clear written 0
   logic       par_en;
   logic       cd_high;
   logic       halt;
   logic       gate_high;
   logic [7:0] flags;       // Bits 7..4 and 1 as stored
   modport src  (output rx_load, rx_par_bad, rx_stop_bad, rx_shift_full, rx_read,
                 tx_write, tx_move, err_clear, par_en, cd_high, halt, gate_high,
                 input flags);
   modport sink (input rx_load, rx_par_bad, rx_stop_bad, rx_shift_full, rx_read,
                 tx_write, tx_move, err_clear, par_en, cd_high, halt, gate_high,
                 output flags);
endinterface : ascst_ev_if
`default_nettype wire

// ### shared/ascst_pkg.sv
// Package with register map, field positions and reset values of the serial status block
`default_nettype none
package ascst_pkg;
   // ---------------------------------------------------------------
   // Register map (byte addresses, printed offsets are word indices)
   // ---------------------------------------------------------------
   localparam logic [3:0] ASCST_IDX_STATUS  = 4'h5;  // channel1_serial_status
   localparam logic [3:0] ASCST_IDX_CONTROL = 4'h0;  // channel_control_a subset
   localparam logic [3:0] ASCST_IDX_RXDATA  = 4'h1;  // receive_data_register
   localparam logic [3:0] ASCST_IDX_TXDATA  = 4'h2;  // transmit_data_register
   localparam logic [3:0] ASCST_IDX_IRQST   = 4'h3;  // sticky event status
   localparam logic [3:0] ASCST_IDX_IRQMSK  = 4'h4;  // event mask
   localparam int ASCST_ADDR_W = 6;
   // ---------------------------------------------------------------
   // Status fields
   // ---------------------------------------------------------------
   localparam int ASCST_B_RDF  = 7;
   localparam int ASCST_B_OVR  = 6;
   localparam int ASCST_B_PAR  = 5;
   localparam int ASCST_B_FRM  = 4;
   localparam int ASCST_B_RIE  = 3;
   localparam int ASCST_B_SEL  = 2;
   localparam int ASCST_B_TDE  = 1;
   localparam int ASCST_B_TIE  = 0;
   // Control fields
   localparam int ASCST_B_EFC  = 3;  // error_flag_clear, acts when written 0
   localparam int ASCST_B_PEN  = 1;  // parity_select_bit
   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] ASCST_RST_CTRL = 8'h08;
   localparam logic [7:0] ASCST_RST_ZERO = 8'h00;
   // Sticky event bits
   localparam int ASCST_E_RX  = 0;
   localparam int ASCST_E_TX  = 1;
   localparam int ASCST_E_CD  = 2;
   localparam int ASCST_EV_W  = 3;
endpackage : ascst_pkg
`default_nettype wire
